// [logic/ecc_pkg.sv]
// Constants for the DRAM ECC and loopback check block.
// Assumes a 32-bit APB slave with byte addresses and word-aligned registers.
package ecc_pkg;
  // Register byte offsets
  localparam logic [11:0] LB_CTRL_LO = 12'h270;
  localparam logic [11:0] LB_CTRL_HI = 12'h274;
  localparam logic [11:0] LB_OBS_A_LO = 12'h278;
  localparam logic [11:0] LB_OBS_A_HI = 12'h27c;
  localparam logic [11:0] LB_OBS_B_LO = 12'h280;
  localparam logic [11:0] LB_OBS_B_HI = 12'h284;
  localparam logic [11:0] LB_OBS_C_LO = 12'h288;
  localparam logic [11:0] LB_OBS_C_HI = 12'h28c;
  localparam logic [11:0] ECC_CTRL = 12'h290;
  localparam logic [11:0] ECC_STATUS = 12'h294;
  localparam logic [11:0] ECC_CLEAR = 12'h298;
  localparam logic [11:0] ECC_IRQ_EN = 12'h29c;
  localparam logic [11:0] ECC_LOG_CODE = 12'h2a0;
  localparam logic [11:0] ECC_LOG_ADDR = 12'h2a4;
  localparam logic [11:0] ECC_LOG_DLO = 12'h2a8;
  localparam logic [11:0] ECC_LOG_DHI = 12'h2ac;
  localparam logic [11:0] CFG_STATUS = 12'h2b0;
  // Loopback control field positions
  localparam int LB_EN_BIT = 0;
  localparam int LB_START_BIT = 1;
  localparam int LB_ERR_BIT = 8;
  // ECC control field positions
  localparam int ECC_ON_BIT = 0;
  localparam int ECC_RD_RESP_BIT = 1;
  localparam int ECC_WR_RESP_BIT = 2;
  localparam int ECC_TRIG2_BIT = 3;
  // Interrupt vector positions
  localparam int VEC_ANY_BIT = 0;
  localparam int VEC_TWO_BIT = 1;
  // Configuration / status positions
  localparam int CFG_W64_BIT = 0;
  localparam int CFG_LOCK_BIT = 8;
  localparam int CFG_TSEL_BIT = 9;
  // Reset values
  localparam logic [1:0] LB_CTRL_RST = 2'h0;
  localparam logic [3:0] ECC_CTRL_RST = 4'h0;
  localparam logic [1:0] IRQ_EN_RST = 2'h0;
  localparam logic [1:0] VEC_RST = 2'h0;
  localparam logic CFG_W64_RST = 1'b0;
endpackage : ecc_pkg

// [logic/bit_sync.sv]
// Two-flop synchroniser for levels from outside the clock domain.
// Assumes inputs are quasi-static levels.
`timescale 1ns/1ps
module bit_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Data
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] meta_q;

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule : bit_sync

// [logic/first_capture.sv]
// Holds the first captured word until rearmed.
// Assumes i_cap and i_rearm come from the same clock domain.
`timescale 1ns/1ps
module first_capture #(
  parameter int W = 64
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // Control
  input wire logic i_cap,
  input wire logic i_rearm,
  input wire logic [W-1:0] i_data,
  // State
  output logic o_held,
  output logic [W-1:0] o_data
);
  logic take;

  assign take = i_cap && (!o_held || i_rearm);

  // Capture beats rearm in the same cycle
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_held <= 1'b0;
    end else if (i_cap) begin
      o_held <= 1'b1;
    end else if (i_rearm) begin
      o_held <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_data <= '0;
    end else if (take) begin
      o_data <= i_data;
    end
  end
endmodule : first_capture

// [logic/dram_ecc_and_loopback_check.sv]
// DRAM controller error checking: PHY loopback compare and ECC control.
// Assumes an APB master, a PHY loop data stream and an ECC checker on
// i_mclk; test-port pins and the lock flag arrive asynchronously.
//
// Contract
// - Test-select input picks test-port or register loopback controls.
// - Writing 1 to the loop start bit begins the loop data test.
// - Mismatch raises a flag; first bad received and expected are kept.
// - ECC works only when the data path is 64 bits wide.
// - ECC control bit 0 gates all checking and reporting.
// - Control bit 1: two-bit read error gives a read response error.
// - Control bit 2: two-bit error in read-before-write gives write error.
// - Only the first qualifying error is logged until software handles it.
// - Control bit 3 low logs any error; high logs two-bit errors only.
// - Logging is armed only while the matching vector bit is clear.
// - ECC errors also raise an interrupt gated by an enable register.
// - Vector bit 0 sets on any ECC error, bit 1 on two-bit errors.
// - Writing 1 clears a vector bit; writing 0 leaves it.
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
module dram_ecc_and_loopback_check
  import ecc_pkg::*;
#(
  parameter int DW = 64,
  parameter int AW = 32,
  parameter int SW = 8
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Test port pins and lock flag
  input wire logic i_test_sel,
  input wire logic i_test_lb_en,
  input wire logic i_test_lb_start,
  input wire logic i_dll_locked,
  // Loopback compare stream
  input wire logic i_lb_valid,
  input wire logic [DW-1:0] i_lb_rdata,
  input wire logic [DW-1:0] i_lb_expdata,
  // ECC checker results
  input wire logic i_ecc_valid,
  input wire logic i_ecc_err1,
  input wire logic i_ecc_err2,
  input wire logic i_ecc_partial_wr,
  input wire logic [SW-1:0] i_ecc_syndrome,
  input wire logic [AW-1:0] i_ecc_addr,
  input wire logic [DW-1:0] i_ecc_data,
  // Loopback controls to PHY
  output logic o_lb_en,
  output logic o_lb_start,
  output logic o_lb_error,
  // Responses and interrupt
  output logic o_rd_resp_err,
  output logic o_wr_resp_err,
  output logic o_irq
);
  logic [3:0] pin_s;
  logic tsel_s;
  logic tlb_en_s;
  logic tlb_start_s;
  logic lock_s;
  logic [1:0] lb_ctrl_q;
  logic [3:0] ecc_ctrl_q;
  logic [1:0] irq_en_q;
  logic [1:0] vec_q;
  logic [1:0] vec_d;
  logic w64_q;
  logic eff_en;
  logic eff_start;
  logic start_q;
  logic lb_run;
  logic lb_rearm;
  logic lb_mis;
  logic [31:0] word_q;
  logic [DW-1:0] obs_rd;
  logic [DW-1:0] obs_exp;
  logic [31:0] obs_idx;
  logic ecc_on;
  logic ev_any;
  logic ev_two;
  logic log_trig;
  logic log_arm;
  logic log_held;
  logic [SW+AW+DW-1:0] log_q;
  logic setup;
  logic wr_en;
  logic [1:0] clr;
  logic [31:0] rdata;
  logic hit;

  // Pins cross into the clock domain
  bit_sync #(.W(4)) u_pin_sync (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_async({i_dll_locked, i_test_lb_start, i_test_lb_en, i_test_sel}),
    .o_sync(pin_s)
  );
  assign tsel_s = pin_s[0];
  assign tlb_en_s = pin_s[1];
  assign tlb_start_s = pin_s[2];
  assign lock_s = pin_s[3];

  // APB phases
  assign setup = i_psel && !i_penable;
  assign wr_en = i_psel && i_penable && i_pwrite && o_pready;
  assign clr = (wr_en && i_paddr == ECC_CLEAR) ? i_pwdata[1:0] : 2'h0;

  // Register-side loopback control
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lb_ctrl_q <= LB_CTRL_RST;
    end else if (wr_en && i_paddr == LB_CTRL_LO) begin
      lb_ctrl_q <= {i_pwdata[LB_START_BIT], i_pwdata[LB_EN_BIT]};
    end
  end

  // ECC control, interrupt enable and width configuration
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ecc_ctrl_q <= ECC_CTRL_RST;
      irq_en_q <= IRQ_EN_RST;
      w64_q <= CFG_W64_RST;
    end else if (wr_en) begin
      if (i_paddr == ECC_CTRL) begin
        ecc_ctrl_q <= i_pwdata[3:0];
      end else if (i_paddr == ECC_IRQ_EN) begin
        irq_en_q <= i_pwdata[1:0];
      end else if (i_paddr == CFG_STATUS) begin
        w64_q <= i_pwdata[CFG_W64_BIT];
      end
    end
  end

  // Test port or register controls
  assign eff_en = tsel_s ? tlb_en_s : lb_ctrl_q[0];
  assign eff_start = tsel_s ? tlb_start_s : lb_ctrl_q[1];
  assign lb_run = eff_en && eff_start;
  assign lb_rearm = !eff_start || (eff_start && !start_q);
  assign lb_mis = lb_run && i_lb_valid && (i_lb_rdata != i_lb_expdata);

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      start_q <= 1'b0;
      o_lb_en <= 1'b0;
      o_lb_start <= 1'b0;
    end else begin
      start_q <= eff_start;
      o_lb_en <= eff_en;
      o_lb_start <= lb_run;
    end
  end

  // Index of the word being compared
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      word_q <= 32'h0;
    end else if (!lb_run) begin
      word_q <= 32'h0;
    end else if (i_lb_valid) begin
      word_q <= word_q + 32'h1;
    end
  end

  // First mismatch capture
  first_capture #(.W(2 * DW + 32)) u_lb_cap (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_cap(lb_mis),
    .i_rearm(lb_rearm),
    .i_data({i_lb_rdata, i_lb_expdata, word_q}),
    .o_held(o_lb_error),
    .o_data({obs_rd, obs_exp, obs_idx})
  );

  // ECC events
  assign ecc_on = ecc_ctrl_q[ECC_ON_BIT] && w64_q;
  assign ev_any = ecc_on && i_ecc_valid && (i_ecc_err1 || i_ecc_err2);
  assign ev_two = ecc_on && i_ecc_valid && i_ecc_err2;
  assign log_trig = ecc_ctrl_q[ECC_TRIG2_BIT] ? ev_two : ev_any;
  assign log_arm = ecc_ctrl_q[ECC_TRIG2_BIT] ? !vec_q[VEC_TWO_BIT] :
                   !vec_q[VEC_ANY_BIT];

  // Set wins over a same-cycle clear
  assign vec_d = (vec_q & ~clr) | {ev_two, ev_any};

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      vec_q <= VEC_RST;
    end else begin
      vec_q <= vec_d;
    end
  end

  // First error log
  first_capture #(.W(SW + AW + DW)) u_ecc_log (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_cap(log_trig && log_arm),
    .i_rearm(log_arm),
    .i_data({i_ecc_syndrome, i_ecc_addr, i_ecc_data}),
    .o_held(log_held),
    .o_data(log_q)
  );

  // Responses and interrupt
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rd_resp_err <= 1'b0;
      o_wr_resp_err <= 1'b0;
      o_irq <= 1'b0;
    end else begin
      o_rd_resp_err <= ev_two && !i_ecc_partial_wr &&
                       ecc_ctrl_q[ECC_RD_RESP_BIT];
      o_wr_resp_err <= ev_two && i_ecc_partial_wr &&
                       ecc_ctrl_q[ECC_WR_RESP_BIT];
      o_irq <= |(vec_d & irq_en_q);
    end
  end

  // Read decode
  always_comb begin
    rdata = 32'h0;
    hit = 1'b1;
    if (i_paddr == LB_CTRL_LO) begin
      rdata[LB_EN_BIT] = lb_ctrl_q[0];
      rdata[LB_START_BIT] = lb_ctrl_q[1];
      rdata[LB_ERR_BIT] = o_lb_error;
    end else if (i_paddr == LB_CTRL_HI) begin
      rdata = 32'h0;
    end else if (i_paddr == LB_OBS_A_LO) begin
      rdata = obs_rd[31:0];
    end else if (i_paddr == LB_OBS_A_HI) begin
      rdata = obs_rd[63:32];
    end else if (i_paddr == LB_OBS_B_LO) begin
      rdata = obs_exp[31:0];
    end else if (i_paddr == LB_OBS_B_HI) begin
      rdata = obs_exp[63:32];
    end else if (i_paddr == LB_OBS_C_LO) begin
      rdata = obs_idx;
    end else if (i_paddr == LB_OBS_C_HI) begin
      rdata = 32'h0;
    end else if (i_paddr == ECC_CTRL) begin
      rdata[3:0] = ecc_ctrl_q;
    end else if (i_paddr == ECC_STATUS) begin
      rdata[1:0] = vec_q;
    end else if (i_paddr == ECC_CLEAR) begin
      rdata = 32'h0;
    end else if (i_paddr == ECC_IRQ_EN) begin
      rdata[1:0] = irq_en_q;
    end else if (i_paddr == ECC_LOG_CODE) begin
      rdata[SW-1:0] = log_q[SW+AW+DW-1:AW+DW];
    end else if (i_paddr == ECC_LOG_ADDR) begin
      rdata = log_q[AW+DW-1:DW];
    end else if (i_paddr == ECC_LOG_DLO) begin
      rdata = log_q[31:0];
    end else if (i_paddr == ECC_LOG_DHI) begin
      rdata = log_q[63:32];
    end else if (i_paddr == CFG_STATUS) begin
      rdata[CFG_W64_BIT] = w64_q;
      rdata[CFG_LOCK_BIT] = lock_s;
      rdata[CFG_TSEL_BIT] = tsel_s;
    end else begin
      hit = 1'b0;
    end
  end

  // One access cycle, data sampled in setup
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_prdata <= 32'h0;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= setup;
      o_pslverr <= setup && !hit;
      o_prdata <= (setup && !i_pwrite) ? rdata : 32'h0;
    end
  end

  // Checks
  vec_sticky_a: assert property (
    @(posedge i_mclk) disable iff (!i_arst_n)
    vec_q[0] && !clr[0] |=> vec_q[0])
    else $error("vector bit 0 dropped without clear");
  vec_clr_a: assert property (
    @(posedge i_mclk) disable iff (!i_arst_n)
    clr[0] && !ev_any |=> !vec_q[0])
    else $error("vector bit 0 not cleared by write of 1");
  vec_set_a: assert property (
    @(posedge i_mclk) disable iff (!i_arst_n)
    ev_two |=> vec_q[1] && vec_q[0])
    else $error("two-bit error did not set both vector bits");
  ecc_gate_a: assert property (
    @(posedge i_mclk) disable iff (!i_arst_n)
    !ecc_on |=> (vec_q & ~$past(vec_q)) == 2'h0)
    else $error("vector set while ecc off");
  width_gate_a: assert property (
    @(posedge i_mclk) disable iff (!i_arst_n)
    !w64_q |=> !o_rd_resp_err && !o_wr_resp_err)
    else $error("ecc response error outside 64-bit mode");
  rd_resp_a: assert property (
    @(posedge i_mclk) disable iff (!i_arst_n)
    o_rd_resp_err |-> $past(ev_two) && $past(ecc_ctrl_q[1]) &&
    !$past(i_ecc_partial_wr))
    else $error("read response error without cause");
  wr_resp_a: assert property (
    @(posedge i_mclk) disable iff (!i_arst_n)
    ev_two && i_ecc_partial_wr && ecc_ctrl_q[2] |=> o_wr_resp_err)
    else $error("write response error missing");
  log_hold_a: assert property (
    @(posedge i_mclk) disable iff (!i_arst_n)
    !log_arm |=> $stable(log_q))
    else $error("ecc log overwritten while pending");
  log_pend_a: assert property (
    @(posedge i_mclk) disable iff (!i_arst_n)
    log_trig && log_arm |=> log_held)
    else $error("ecc log not marked pending");
  log_trig_a: assert property (
    @(posedge i_mclk) disable iff (!i_arst_n)
    ecc_ctrl_q[3] && ev_any && !ev_two |=> $stable(log_q))
    else $error("single-bit error logged in two-bit mode");
  log_arm_a: assert property (
    @(posedge i_mclk) disable iff (!i_arst_n)
    log_trig && log_arm |=> log_q == $past({i_ecc_syndrome, i_ecc_addr,
    i_ecc_data}))
    else $error("first error not logged");
  irq_gate_a: assert property (
    @(posedge i_mclk) disable iff (!i_arst_n)
    o_irq |-> |($past(vec_d) & $past(irq_en_q)))
    else $error("interrupt without enabled vector");
  lb_flag_a: assert property (
    @(posedge i_mclk) disable iff (!i_arst_n)
    lb_mis |=> o_lb_error)
    else $error("mismatch flag not raised");
  lb_hold_a: assert property (
    @(posedge i_mclk) disable iff (!i_arst_n)
    o_lb_error && eff_start && start_q |=> o_lb_error && $stable(obs_rd))
    else $error("loop capture lost while running");
  lb_start_a: assert property (
    @(posedge i_mclk) disable iff (!i_arst_n)
    !tsel_s && lb_ctrl_q == 2'h3 |=> o_lb_start)
    else $error("loop start not issued");
  tsel_a: assert property (
    @(posedge i_mclk) disable iff (!i_arst_n)
    tsel_s && !tlb_start_s |=> !o_lb_start)
    else $error("register start used under test select");
endmodule : dram_ecc_and_loopback_check

// [tb/mem_side_model.sv]
// Far-side model: PHY loop data stream and ECC checker results.
// Assumes the loop runs while the design drives enable and start high.
`timescale 1ns/1ps
module mem_side_model (
  // Clock and loop controls
  input wire logic i_mclk,
  input wire logic i_lb_en,
  input wire logic i_lb_start,
  input wire logic [31:0] i_bad_idx,
  // Loop stream
  output logic o_lb_valid = 1'b0,
  output logic [63:0] o_lb_rdata = 64'h0,
  output logic [63:0] o_lb_expdata = 64'h0,
  // ECC results
  output logic o_ecc_valid = 1'b0,
  output logic o_ecc_err1 = 1'b0,
  output logic o_ecc_err2 = 1'b0,
  output logic o_ecc_partial_wr = 1'b0,
  output logic [7:0] o_ecc_syndrome = 8'h0,
  output logic [31:0] o_ecc_addr = 32'h0,
  output logic [63:0] o_ecc_data = 64'h0
);
  logic [31:0] idx_q = 32'h0;
  // Words from the bad index on are corrupted in bit 0
  always @(posedge i_mclk) begin
    if (i_lb_en && i_lb_start) begin
      o_lb_valid <= 1'b1;
      o_lb_expdata <= {idx_q, ~idx_q};
      o_lb_rdata <= {idx_q, ~idx_q ^ {31'h0, idx_q >= i_bad_idx}};
      idx_q <= idx_q + 32'h1;
    end else begin
      o_lb_valid <= 1'b0;
      o_lb_rdata <= ~o_lb_rdata;
      idx_q <= 32'h0;
    end
  end
  // One checked access; lines show junk once valid drops
  task automatic ecc_event(input logic e1, e2, pw, input logic [7:0] s,
      input logic [31:0] a);
    o_ecc_valid <= 1'b1;
    o_ecc_err1 <= e1;
    o_ecc_err2 <= e2;
    o_ecc_partial_wr <= pw;
    o_ecc_syndrome <= s;
    o_ecc_addr <= a;
    o_ecc_data <= {a, ~a};
    @(posedge i_mclk);
    o_ecc_valid <= 1'b0;
    o_ecc_err1 <= ~e1;
    o_ecc_err2 <= ~e2;
    o_ecc_syndrome <= ~s;
    o_ecc_addr <= ~a;
    o_ecc_data <= {~a, a};
  endtask : ecc_event
endmodule : mem_side_model

// [tb/tb.sv]
// Testbench: APB register tests of loop check and ECC control.
// Assumes the far-side model drives loop stream and ECC results.
`timescale 1ns/1ps
module tb;
  import ecc_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd_q;
  logic pready, pslverr, slverr_q;
  logic test_sel = 1'b0, test_en = 1'b0, test_start = 1'b0;
  logic dll_lock = 1'b0;
  logic [31:0] bad_idx = 32'h3;
  logic lb_valid, ecc_valid, err1, err2, part, lb_en, lb_start, lb_error;
  logic rd_err, wr_err, irq;
  logic [63:0] lb_rdata, lb_exp, ecc_data;
  logic [7:0] syn;
  logic [31:0] ecc_addr;
  int failures = 0, checks = 0;
  always #50 mclk = ~mclk;
  dram_ecc_and_loopback_check u_dram_ecc_and_loopback_check (
    .i_mclk(mclk), .i_arst_n(arst_n), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_test_sel(test_sel), .i_test_lb_en(test_en),
    .i_test_lb_start(test_start), .i_dll_locked(dll_lock),
    .i_lb_valid(lb_valid), .i_lb_rdata(lb_rdata), .i_lb_expdata(lb_exp),
    .i_ecc_valid(ecc_valid), .i_ecc_err1(err1), .i_ecc_err2(err2),
    .i_ecc_partial_wr(part), .i_ecc_syndrome(syn), .i_ecc_addr(ecc_addr),
    .i_ecc_data(ecc_data), .o_lb_en(lb_en), .o_lb_start(lb_start),
    .o_lb_error(lb_error), .o_rd_resp_err(rd_err), .o_wr_resp_err(wr_err),
    .o_irq(irq));
  mem_side_model u_mem_side_model (
    .i_mclk(mclk), .i_lb_en(lb_en), .i_lb_start(lb_start),
    .i_bad_idx(bad_idx), .o_lb_valid(lb_valid), .o_lb_rdata(lb_rdata),
    .o_lb_expdata(lb_exp), .o_ecc_valid(ecc_valid), .o_ecc_err1(err1),
    .o_ecc_err2(err2), .o_ecc_partial_wr(part), .o_ecc_syndrome(syn),
    .o_ecc_addr(ecc_addr), .o_ecc_data(ecc_data));
  task automatic stop_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input string n, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One APB transfer; releases and lets an edge pass
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      failures++;
      stop_test();
    end
    rd_q = prdata;
    slverr_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task automatic rd(input string n, input logic [11:0] a,
      input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, rd_q, e);
  endtask : rd
  task automatic ev(input logic e1, e2, pw, input logic [7:0] s,
      input logic [31:0] a, input logic xr, xw);
    u_mem_side_model.ecc_event(e1, e2, pw, s, a);
    @(posedge mclk);
    chk("rd_resp", {31'h0, rd_err}, {31'h0, xr});
    chk("wr_resp", {31'h0, wr_err}, {31'h0, xw});
  endtask : ev
  initial begin
    int n;
    repeat (6) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    rd("lb_ctrl", LB_CTRL_LO, 32'h0);
    rd("ecc_ctrl", ECC_CTRL, 32'h0);
    rd("vector", ECC_STATUS, 32'h0);
    rd("irq_en", ECC_IRQ_EN, 32'h0);
    rd("unmapped", 12'h3f0, 32'h0);
    chk("slverr", {31'h0, slverr_q}, 32'h1);
    $display("test reset done");
    dll_lock <= 1'b1;
    n = 0;
    do begin
      apb(1'b0, CFG_STATUS, 32'h0);
      n++;
    end while (rd_q[CFG_LOCK_BIT] !== 1'b1 && n < 8);
    chk("lock", {31'h0, rd_q[CFG_LOCK_BIT]}, 32'h1);
    apb(1'b1, LB_CTRL_LO, 32'h1);
    apb(1'b1, LB_CTRL_LO, 32'h3);
    n = 0;
    while (lb_error !== 1'b1 && n < 40) begin
      @(posedge mclk);
      n++;
    end
    chk("lb_start", {31'h0, lb_start}, 32'h1);
    rd("lb_status", LB_CTRL_LO, 32'h103);
    rd("obs_rx", LB_OBS_A_LO, 32'hfffffffd);
    rd("obs_rx_hi", LB_OBS_A_HI, 32'h3);
    rd("obs_exp", LB_OBS_B_LO, 32'hfffffffc);
    rd("obs_idx", LB_OBS_C_LO, 32'h3);
    apb(1'b1, LB_CTRL_LO, 32'h1);
    rd("lb_stopped", LB_CTRL_LO, 32'h1);
    chk("lb_error", {31'h0, lb_error}, 32'h0);
    $display("test loop done");
    apb(1'b1, ECC_IRQ_EN, 32'h3);
    apb(1'b1, ECC_CTRL, 32'hf);
    ev(1'b0, 1'b1, 1'b0, 8'h11, 32'h100, 1'b0, 1'b0);
    rd("vec_w32", ECC_STATUS, 32'h0);
    apb(1'b1, CFG_STATUS, 32'h1);
    apb(1'b1, ECC_CTRL, 32'h0);
    ev(1'b0, 1'b1, 1'b0, 8'h11, 32'h100, 1'b0, 1'b0);
    rd("vec_off", ECC_STATUS, 32'h0);
    apb(1'b1, ECC_CTRL, 32'h1);
    ev(1'b1, 1'b0, 1'b0, 8'h11, 32'h1000, 1'b0, 1'b0);
    ev(1'b1, 1'b0, 1'b0, 8'h22, 32'h2000, 1'b0, 1'b0);
    rd("vec_one", ECC_STATUS, 32'h1);
    rd("log_code", ECC_LOG_CODE, 32'h11);
    rd("log_addr", ECC_LOG_ADDR, 32'h1000);
    chk("irq", {31'h0, irq}, 32'h1);
    apb(1'b1, ECC_CLEAR, 32'h0);
    rd("vec_keep", ECC_STATUS, 32'h1);
    apb(1'b1, ECC_CLEAR, 32'h1);
    rd("vec_clr", ECC_STATUS, 32'h0);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    apb(1'b1, ECC_CTRL, 32'hf);
    ev(1'b1, 1'b0, 1'b0, 8'h33, 32'h3000, 1'b0, 1'b0);
    rd("log_mode2", ECC_LOG_CODE, 32'h11);
    ev(1'b0, 1'b1, 1'b0, 8'h44, 32'h4000, 1'b1, 1'b0);
    rd("vec_two", ECC_STATUS, 32'h3);
    rd("log_two", ECC_LOG_CODE, 32'h44);
    rd("log_dlo", ECC_LOG_DLO, 32'hffffbfff);
    rd("log_dhi", ECC_LOG_DHI, 32'h4000);
    ev(1'b0, 1'b1, 1'b1, 8'h55, 32'h5000, 1'b0, 1'b1);
    rd("log_hold", ECC_LOG_CODE, 32'h44);
    apb(1'b1, ECC_IRQ_EN, 32'h0);
    @(posedge mclk);
    chk("irq_mask", {31'h0, irq}, 32'h0);
    apb(1'b1, ECC_CLEAR, 32'h3);
    rd("vec_clr2", ECC_STATUS, 32'h0);
    $display("test ecc done");
    test_en <= 1'b1;
    test_start <= 1'b1;
    test_sel <= 1'b1;
    repeat (8) @(posedge mclk); // fixed wait for the test pins to pass the synchroniser
    chk("pin_en", {31'h0, lb_en}, 32'h1);
    chk("pin_start", {31'h0, lb_start}, 32'h1);
    rd("cfg_tsel", CFG_STATUS, 32'h301);
    $display("test pins done");
    stop_test();
  end
endmodule : tb
